// ===== rtl/dmas_slice.sv
// Multiply-accumulate slice top: pre-adder, multiplier, SIMD ALU, logic unit, XOR, pattern detect
//
// Function
// RL1 - Signed 27 by 18 multiply, product added into 48-bit accumulator.
// RL2 - Multiplier bypass on demand; two 48-bit operands feed the ALU.
// RL3 - SIMD split into two 24-bit or four 12-bit lanes, no carries between.
// RL4 - Logic unit gives one of ten bitwise functions of two operands.
// RL5 - Pre-adder combines two operands ahead of the multiplier.
// RL6 - 96-bit XOR reduction, segments of 12, 24, 48 or 96 bits.
// RL7 - 48-bit pattern detector on result, match usable for rounding.
// RL8 - Pattern detector with logic unit evaluates 96-bit-wide logic functions.
// RL9 - Accumulator works as up/down counter on each enabled edge.
// RL10 - All registers on one rising clock, own enables, synchronous clear.
`timescale 1ns/1ps
module dmas_slice
	import dmas_pkg::*;
(
	input  wire logic         clk_sys_i,
	input  wire logic         resetn_i,
	input  wire logic         ce_in_i,
	input  wire logic         ce_mul_i,
	input  wire logic         ce_p_i,
	input  dmas_in_type       ctl_i,
	output dmas_out_type      res_o
);
	typedef struct packed {
		dmas_in_type          in;
		logic [DMAS_M_W-1:0]  m;
		dmas_op_type          op_m;
		logic                 byp_m;
		logic [DMAS_P_W-1:0]  x_m;
		logic [DMAS_P_W-1:0]  y_m;
		dmas_out_type         out;
	} dmas_state_type;

	dmas_state_type st_ff;
	dmas_state_type nxt_st;
	logic signed [DMAS_A_W-1:0] pre_sum;
	logic signed [DMAS_M_W-1:0] prod;
	logic [DMAS_P_W-1:0]        alu_x;
	logic [DMAS_P_W-1:0]        alu_y;
	logic                       alu_sub;
	logic [DMAS_P_W-1:0]        alu_sum;
	logic [DMAS_P_W-1:0]        lu_out;
	logic [DMAS_P_W-1:0]        res_new;
	logic [DMAS_X_W-1:0]        xcat;
	logic [DMAS_XSEG_N-1:0]     x12;
	logic [DMAS_XSEG_N-1:0]     xor_new;
	logic                       mt_new;
	logic                       mtb_new;

	// Pre-adder and signed multiplier stage
	always_comb
	begin
		pre_sum = st_ff.in.use_pre
			? (st_ff.in.pre_sub ? st_ff.in.d - st_ff.in.a : st_ff.in.d + st_ff.in.a) // RL5
			: st_ff.in.a;
		prod = pre_sum * $signed(st_ff.in.b); // RL1
	end

	// Accumulator operand select
	always_comb
	begin
		alu_sub = 1'b0;
		alu_x   = st_ff.out.p;
		alu_y   = st_ff.x_m;
		unique case (st_ff.op_m)
			DMAS_OP_MAC:
			begin
				alu_y = st_ff.byp_m ? st_ff.y_m : {{(DMAS_P_W-DMAS_M_W){st_ff.m[DMAS_M_W-1]}}, st_ff.m}; // RL1 RL2
			end
			DMAS_OP_ADD:
			begin
				alu_x = st_ff.x_m; // RL2
				alu_y = st_ff.y_m;
			end
			DMAS_OP_SUB:
			begin
				alu_x   = st_ff.x_m;
				alu_y   = st_ff.y_m;
				alu_sub = 1'b1;
			end
			DMAS_OP_ACC:    alu_y = st_ff.x_m;
			DMAS_OP_CNT_UP: alu_y = DMAS_P_ONE; // RL9
			DMAS_OP_CNT_DN:
			begin
				alu_y   = DMAS_P_ONE; // RL9
				alu_sub = 1'b1;
			end
			default:        alu_y = st_ff.y_m;
		endcase
	end

	dmas_lane_alu u_alu
	(
		.x_i   (alu_x),
		.y_i   (alu_y),
		.sub_i (alu_sub),
		.simd_i(st_ff.in.simd), // RL3
		.sum_o (alu_sum)
	);

	// Ten logic functions
	always_comb
	begin
		unique case (st_ff.in.lf) // RL4
			DMAS_LF_AND:  lu_out = st_ff.x_m & st_ff.y_m;
			DMAS_LF_OR:   lu_out = st_ff.x_m | st_ff.y_m;
			DMAS_LF_XOR:  lu_out = st_ff.x_m ^ st_ff.y_m;
			DMAS_LF_NAND: lu_out = ~(st_ff.x_m & st_ff.y_m);
			DMAS_LF_NOR:  lu_out = ~(st_ff.x_m | st_ff.y_m);
			DMAS_LF_XNOR: lu_out = ~(st_ff.x_m ^ st_ff.y_m);
			DMAS_LF_ANDN: lu_out = st_ff.x_m & ~st_ff.y_m;
			DMAS_LF_ORN:  lu_out = st_ff.x_m | ~st_ff.y_m;
			DMAS_LF_NOTX: lu_out = ~st_ff.x_m;
			DMAS_LF_NOTY: lu_out = ~st_ff.y_m;
			default:      lu_out = st_ff.x_m;
		endcase
		res_new = (st_ff.op_m == DMAS_OP_LOGIC) ? lu_out : alu_sum;
	end

	// XOR reduction over operand pair, per 12-bit segment then merged
	assign xcat = {st_ff.y_m, st_ff.x_m};
	genvar g;
	generate
		for (g = 0; g < DMAS_XSEG_N; g++)
		begin : g_xor
			assign x12[g] = ^xcat[g*DMAS_L4_W +: DMAS_L4_W]; // RL6
		end
	endgenerate

	always_comb
	begin
		xor_new = DMAS_X_RST;
		unique case (st_ff.in.xw) // RL6
			DMAS_XW_12: xor_new = x12;
			DMAS_XW_24:
			begin
				for (int k = 0; k < DMAS_XSEG_N / 2; k++)
					xor_new[k] = x12[2*k] ^ x12[2*k+1];
			end
			DMAS_XW_48:
			begin
				xor_new[0] = ^x12[3:0];
				xor_new[1] = ^x12[7:4];
			end
			DMAS_XW_96: xor_new[0] = ^x12;
		endcase
		mt_new  = ((res_new ^ st_ff.in.pattern) & ~st_ff.in.mask) == DMAS_P_RST; // RL7
		mtb_new = ((res_new ^ ~st_ff.in.pattern) & ~st_ff.in.mask) == DMAS_P_RST; // RL7
	end

	// Next state with per-stage enables
	always_comb
	begin
		nxt_st = st_ff;
		if (ce_in_i)
			nxt_st.in = ctl_i; // RL10
		if (ce_mul_i)
		begin
			nxt_st.m     = DMAS_M_W'(prod); // RL1
			nxt_st.op_m  = st_ff.in.op;
			nxt_st.byp_m = st_ff.in.bypass; // RL2
			nxt_st.x_m   = st_ff.in.x;
			nxt_st.y_m   = st_ff.in.y;
		end
		if (ce_p_i)
		begin
			nxt_st.out.p          = res_new; // RL1
			nxt_st.out.xor_out    = xor_new;
			nxt_st.out.match      = mt_new;
			nxt_st.out.match_b    = mtb_new;
			nxt_st.out.match_wide = mt_new & st_ff.out.match; // RL8
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!resetn_i)
			st_ff <= '0; // RL10
		else
			st_ff <= nxt_st;
	end

	assign res_o = st_ff.out;

	a_count_up: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL9
		resetn_i && ce_p_i && st_ff.op_m == DMAS_OP_CNT_UP && st_ff.in.simd == DMAS_SIMD_ONE48
		|=> res_o.p == $past(res_o.p) + DMAS_P_ONE)
		else $error("counter did not increment");
	a_count_dn: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL9
		resetn_i && ce_p_i && st_ff.op_m == DMAS_OP_CNT_DN && st_ff.in.simd == DMAS_SIMD_ONE48
		|=> res_o.p == $past(res_o.p) - DMAS_P_ONE)
		else $error("counter did not decrement");
	a_hold_p: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL10
		resetn_i && !ce_p_i |=> $stable(res_o))
		else $error("result moved without enable");
	a_reset_clear: assert property (@(posedge clk_sys_i) // RL10
		!resetn_i |=> res_o.p == DMAS_P_RST)
		else $error("result not cleared by reset");
	a_bypass_add: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL2
		resetn_i && ce_p_i && st_ff.op_m == DMAS_OP_ADD && st_ff.in.simd == DMAS_SIMD_ONE48
		|=> res_o.p == $past(st_ff.x_m) + $past(st_ff.y_m))
		else $error("bypass add wrong");
	a_lane_isolate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL3
		resetn_i && ce_p_i && st_ff.op_m == DMAS_OP_ADD && st_ff.in.simd == DMAS_SIMD_FOUR12
		|=> res_o.p[DMAS_L4_W +: DMAS_L4_W]
			== DMAS_L4_W'($past(st_ff.x_m[DMAS_L4_W +: DMAS_L4_W]) + $past(st_ff.y_m[DMAS_L4_W +: DMAS_L4_W])))
		else $error("lane carry leaked");
	a_logic_xor: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL4
		resetn_i && ce_p_i && st_ff.op_m == DMAS_OP_LOGIC && st_ff.in.lf == DMAS_LF_XOR
		|=> res_o.p == ($past(st_ff.x_m) ^ $past(st_ff.y_m)))
		else $error("logic xor wrong");
	a_match_det: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL7
		resetn_i && ce_p_i
		|=> res_o.match == ((((res_o.p ^ $past(st_ff.in.pattern)) & ~$past(st_ff.in.mask))) == DMAS_P_RST))
		else $error("pattern match wrong");
	a_xor_full: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL6
		resetn_i && ce_p_i && st_ff.in.xw == DMAS_XW_96 |=> res_o.xor_out[0] == ^$past(xcat))
		else $error("xor reduction wrong");
	a_match_wide: assert property (@(posedge clk_sys_i) disable iff (!resetn_i) // RL8
		resetn_i && ce_p_i |=> res_o.match_wide == (res_o.match && $past(res_o.match)))
		else $error("wide match wrong");

	c_mac:   cover property (@(posedge clk_sys_i) ce_p_i && st_ff.op_m == DMAS_OP_MAC && !st_ff.byp_m);
	c_simd4: cover property (@(posedge clk_sys_i) ce_p_i && st_ff.in.simd == DMAS_SIMD_FOUR12);
	c_match: cover property (@(posedge clk_sys_i) res_o.match);
	c_wide:  cover property (@(posedge clk_sys_i) res_o.match_wide);
endmodule : dmas_slice

// ===== rtl/dmas_pkg.sv
// Package of constants, modes and carrier structs for the multiply-accumulate slice
package dmas_pkg;

	localparam int DMAS_A_W    = 27;
	localparam int DMAS_B_W    = 18;
	localparam int DMAS_P_W    = 48;
	localparam int DMAS_X_W    = 96;
	localparam int DMAS_L2_W   = 24;
	localparam int DMAS_L4_W   = 12;
	localparam int DMAS_M_W    = DMAS_A_W + DMAS_B_W;
	localparam int DMAS_XSEG_N = DMAS_X_W / DMAS_L4_W;
	localparam logic [DMAS_P_W-1:0] DMAS_P_RST  = 48'h0000_0000_0000;
	localparam logic [DMAS_P_W-1:0] DMAS_P_ONE  = 48'h0000_0000_0001;
	localparam logic [DMAS_XSEG_N-1:0] DMAS_X_RST = 8'h00;

	typedef enum logic [1:0] {DMAS_SIMD_ONE48, DMAS_SIMD_TWO24, DMAS_SIMD_FOUR12} dmas_simd_type;
	typedef enum logic [1:0] {DMAS_XW_12, DMAS_XW_24, DMAS_XW_48, DMAS_XW_96} dmas_xw_type;
	typedef enum logic [2:0]
	{
		DMAS_OP_MAC, DMAS_OP_ADD, DMAS_OP_SUB, DMAS_OP_ACC, DMAS_OP_LOGIC, DMAS_OP_CNT_UP, DMAS_OP_CNT_DN
	} dmas_op_type;
	typedef enum logic [3:0]
	{
		DMAS_LF_AND, DMAS_LF_OR, DMAS_LF_XOR, DMAS_LF_NAND, DMAS_LF_NOR,
		DMAS_LF_XNOR, DMAS_LF_ANDN, DMAS_LF_ORN, DMAS_LF_NOTX, DMAS_LF_NOTY
	} dmas_lf_type;

	typedef struct packed {
		logic [DMAS_A_W-1:0] a;
		logic [DMAS_A_W-1:0] d;
		logic [DMAS_B_W-1:0] b;
		logic [DMAS_P_W-1:0] x;
		logic [DMAS_P_W-1:0] y;
		logic [DMAS_P_W-1:0] pattern;
		logic [DMAS_P_W-1:0] mask;
		logic                 use_pre;
		logic                 pre_sub;
		logic                 bypass;
		dmas_op_type          op;
		dmas_lf_type          lf;
		dmas_simd_type        simd;
		dmas_xw_type          xw;
	} dmas_in_type;

	typedef struct packed {
		logic [DMAS_P_W-1:0]    p;
		logic [DMAS_XSEG_N-1:0] xor_out;
		logic                   match;
		logic                   match_b;
		logic                   match_wide;
	} dmas_out_type;

endpackage : dmas_pkg

// ===== rtl/dmas_lane_alu.sv
// SIMD adder with carries cut at lane borders
`timescale 1ns/1ps
module dmas_lane_alu
	import dmas_pkg::*;
(
	input  wire logic [DMAS_P_W-1:0] x_i,
	input  wire logic [DMAS_P_W-1:0] y_i,
	input  wire logic                sub_i,
	input  dmas_simd_type            simd_i,
	output logic      [DMAS_P_W-1:0] sum_o
);
	localparam int NSEG = DMAS_P_W / DMAS_L4_W;
	logic [NSEG:0] carry;
	logic [NSEG-1:0] brk;

	always_comb
	begin
		unique case (simd_i)
			DMAS_SIMD_TWO24:  brk = 4'h5;
			DMAS_SIMD_FOUR12: brk = 4'hF;
			default:          brk = 4'h1;
		endcase
	end

	assign carry[0] = sub_i;
	genvar g;
	generate
		for (g = 0; g < NSEG; g++)
		begin : g_seg
			logic          cin;
			logic [DMAS_L4_W:0] s;
			assign cin = brk[g] ? sub_i : carry[g]; // RL3
			assign s = {1'b0, x_i[g*DMAS_L4_W +: DMAS_L4_W]}
				+ {1'b0, (y_i[g*DMAS_L4_W +: DMAS_L4_W] ^ {DMAS_L4_W{sub_i}})}
				+ {{DMAS_L4_W{1'b0}}, cin};
			assign sum_o[g*DMAS_L4_W +: DMAS_L4_W] = s[DMAS_L4_W-1:0];
			assign carry[g+1] = s[DMAS_L4_W];
		end
	endgenerate
endmodule : dmas_lane_alu

// ===== testbench/dmas_fabric_model.sv
// Fabric-side model that drives the slice clock enables
`timescale 1ns/1ps
module dmas_fabric_model
(
	input  wire logic       clk_sys_i,
	input  wire logic [2:0] hold_i,
	output logic            ce_in_o,
	output logic            ce_mul_o,
	output logic            ce_p_o
);
	// A held bit stalls that stage, as slow user logic would
	always @(posedge clk_sys_i)
	begin
		ce_in_o  <= ~hold_i[2];
		ce_mul_o <= ~hold_i[1];
		ce_p_o   <= ~hold_i[0];
	end
endmodule : dmas_fabric_model

// ===== testbench/tb_top.sv
// Self-checking bench for the multiply-accumulate slice
`timescale 1ns/1ps
module tb_top
	import dmas_pkg::*;
;
	logic         clk_sys_i;
	logic         resetn_i   = 1'b0;
	logic [2:0]   hold       = 3'h0;
	logic         ce_in;
	logic         ce_mul;
	logic         ce_p;
	dmas_in_type  ctl_i;
	dmas_in_type  c;
	dmas_out_type res_o;
	int           error_cnt  = 0;
	int           n_compared = 0;
	logic [47:0]  lf_exp [10] = '{48'hC0C0C0C0C0C0, 48'hFCFCFCFCFCFC, 48'h3C3C3C3C3C3C, 48'h3F3F3F3F3F3F,
		48'h030303030303, 48'hC3C3C3C3C3C3, 48'h303030303030, 48'hF3F3F3F3F3F3, 48'h0F0F0F0F0F0F, 48'h333333333333};
	logic [7:0]   xw_exp [4]  = '{8'h13, 8'h04, 8'h02, 8'h01};

	dmas_slice dmas_slice_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_in_i(ce_in),
		.ce_mul_i(ce_mul), .ce_p_i(ce_p), .ctl_i(ctl_i), .res_o(res_o));
	dmas_fabric_model dmas_fabric_model_inst (.clk_sys_i(clk_sys_i), .hold_i(hold),
		.ce_in_o(ce_in), .ce_mul_o(ce_mul), .ce_p_o(ce_p));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	// Clears the slice, applies v and lets n edges pass
	task automatic go(input dmas_in_type v, input int n);
		@(posedge clk_sys_i);
		resetn_i <= 1'b0;
		ctl_i    <= v;
		@(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : go

	task automatic t_mac();
		c = '0;
		c.op = DMAS_OP_MAC;
		c.a = 27'h7FFFFFD;
		c.b = 18'h00005;
		go(c, 3);
		chk("mac", res_o.p, 48'hFFFFFFFFFFF1);
		go(c, 4);
		chk("mac acc", res_o.p, 48'hFFFFFFFFFFE2);
		c.use_pre = 1'b1;
		c.d = 27'h000000A;
		c.a = 27'h0000003;
		c.b = 18'h00002;
		go(c, 3);
		chk("pre add", res_o.p, 48'h00000000001A);
		c.pre_sub = 1'b1;
		go(c, 3);
		chk("pre sub", res_o.p, 48'h00000000000E);
	endtask : t_mac

	task automatic t_byp();
		c = '0;
		c.op = DMAS_OP_MAC;
		c.bypass = 1'b1;
		c.a = 27'h0000007;
		c.b = 18'h00007;
		c.y = 48'h000000001234;
		go(c, 3);
		chk("bypass", res_o.p, 48'h000000001234);
		c.op = DMAS_OP_SUB;
		c.x = 48'h000000000003;
		c.y = 48'h000000000005;
		go(c, 3);
		chk("sub", res_o.p, 48'hFFFFFFFFFFFE);
		c.op = DMAS_OP_ACC;
		c.x = 48'h000000000010;
		go(c, 4);
		chk("acc", res_o.p, 48'h000000000020);
	endtask : t_byp

	task automatic t_simd();
		c = '0;
		c.op = DMAS_OP_ADD;
		c.x = 48'h000FFF000FFF;
		c.y = 48'h001001001001;
		c.simd = DMAS_SIMD_FOUR12;
		go(c, 3);
		chk("four12", res_o.p, 48'h001000001000);
		c.simd = DMAS_SIMD_TWO24;
		c.op = DMAS_OP_SUB;
		c.x = 48'h000000000000;
		go(c, 3);
		chk("two24", res_o.p, 48'hFFEFFFFFEFFF);
		c.simd = DMAS_SIMD_FOUR12;
		c.op = DMAS_OP_CNT_UP;
		go(c, 4);
		chk("cnt lanes", res_o.p, 48'h000000000002);
	endtask : t_simd

	task automatic t_logic();
		c = '0;
		c.op = DMAS_OP_LOGIC;
		c.x = 48'hF0F0F0F0F0F0;
		c.y = 48'hCCCCCCCCCCCC;
		for (int i = 0; i < 10; i++)
		begin
			c.lf = dmas_lf_type'(i);
			go(c, 3);
			chk("logic", res_o.p, lf_exp[i]);
		end
		c.x = 48'h000000001001;
		c.y = 48'h000000000001;
		for (int i = 0; i < 4; i++)
		begin
			c.xw = dmas_xw_type'(i);
			go(c, 3);
			chk("xor", 48'(res_o.xor_out), 48'(xw_exp[i]));
		end
	endtask : t_logic

	task automatic t_pat();
		c = '0;
		c.op = DMAS_OP_ADD;
		c.x = 48'h000000000005;
		c.pattern = 48'h000000000005;
		go(c, 3);
		chk("match", 48'({res_o.match, res_o.match_b, res_o.match_wide}), 48'h000000000004);
		@(posedge clk_sys_i);
		#1;
		chk("wide", 48'(res_o.match_wide), 48'h000000000001);
		c.pattern = 48'hFFFFFFFFFFFA;
		go(c, 3);
		chk("match inv", 48'({res_o.match, res_o.match_b}), 48'h000000000001);
		c.pattern = 48'h000000000004;
		c.mask = 48'h000000000001;
		go(c, 3);
		chk("masked", 48'(res_o.match), 48'h000000000001);
	endtask : t_pat

	task automatic t_cnt();
		c = '0;
		c.op = DMAS_OP_CNT_UP;
		go(c, 5);
		chk("cnt up", res_o.p, 48'h000000000003);
		c.op = DMAS_OP_CNT_DN;
		go(c, 3);
		chk("cnt dn", res_o.p, 48'hFFFFFFFFFFFF);
		hold <= 3'h1;
		go(c, 4);
		chk("stalled", res_o.p, 48'h000000000000);
		hold <= 3'h0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		chk("released", res_o.p, 48'hFFFFFFFFFFFF);
		@(posedge clk_sys_i);
		resetn_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		chk("cleared", res_o.p, 48'h000000000000);
		chk("cleared flags", 48'({res_o.xor_out, res_o.match, res_o.match_b, res_o.match_wide}), 48'h000000000000);
	endtask : t_cnt

	initial
	begin
		ctl_i = '0;
		repeat (6) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		t_mac();
		t_byp();
		t_simd();
		t_logic();
		t_pat();
		t_cnt();
		give_verdict();
	end

	initial
	begin
		repeat (3000) @(posedge clk_sys_i);
		error_cnt++;
		give_verdict();
	end
endmodule : tb_top
